// ### bench/ims_core_bench.sv
`timescale 1ns/1ns

module ims_core_bench;
  logic        ref_clk;
  logic        rstn;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        scl_oe;
  logic        sda_oe;
  logic        p_scl_oe;
  logic        p_sda_oe;
  logic        irq;
  logic [31:0] rv;
  logic [7:0]  byte_seen;
  int          err_total;
  int          compares;
  int          cyc;
  int          n;
  wire         scl = ~(scl_oe | p_scl_oe);
  wire         sda = ~(sda_oe | p_sda_oe);

  ims_core #(.SCL_QTR_CYC(4)) i_ims_core (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .scl_i     (scl),
    .scl_o     (),
    .scl_oe    (scl_oe),
    .sda_i     (sda),
    .sda_o     (),
    .sda_oe    (sda_oe),
    .irq       (irq)
  );

  ims_peer i_ims_peer (
    .scl_oe (p_scl_oe),
    .sda_oe (p_sda_oe)
  );

  always #10 ref_clk = ~ref_clk;

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic settle();
    repeat (12) @(posedge ref_clk);
  endtask

  task automatic results();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Ceiling far above the expected run length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  initial begin
    ref_clk   = 1'b0;
    rstn      = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    chk("line drive", {scl_oe, sda_oe, irq}, 32'h0000_0000);
    rd(8'h14); chk("div", rv, 32'h0000_0004);
    // Quarter counts below two are refused
    wr(8'h14, 32'h0000_0001);
    rd(8'h14); chk("div refuse", rv, 32'h0000_0004);
    rd(8'h20); chk("unmapped", rv, 32'h0000_0000);
    rd(8'h04); chk("stat idle", rv, 32'h0000_0000);
    wr(8'h10, 32'h0000_0001);
    i_ims_peer.start();
    settle();
    rd(8'h04); chk("stat busy", rv, 32'h0000_0001);
    wr(8'h00, 32'h0000_000D);
    rd(8'h04); chk("stat wait", rv, 32'h0000_0003);
    i_ims_peer.clocks(2);
    settle();
    rd(8'h0C); chk("ifg idle tx", rv, 32'h0000_0003);
    chk("irq tx", irq, 1'b1);
    wr(8'h08, 32'h0000_00FF);
    wr(8'h0C, 32'h0000_0001);
    settle();
    chk("irq clr", irq, 1'b0);
    i_ims_peer.stop();
    // Start follows release with no free-time gap
    n = 0;
    while (!sda_oe && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk("start gap", n < 20, 1'b1);
    settle();
    rd(8'h00); chk("ctrl start done", rv, 32'h0000_000C);
    rd(8'h0C); chk("ifg start", rv, 32'h0000_0003);
    wr(8'h08, 32'h0000_00A5);
    for (int i = 0; i < 8; i++) begin
      @(posedge scl);
      byte_seen = {byte_seen[6:0], sda};
    end
    chk("byte", byte_seen, 8'hA5);
    repeat (40) @(posedge ref_clk);
    rd(8'h0C); chk("ifg nack", rv, 32'h0000_000A);
    wr(8'h10, 32'h0000_0008);
    settle();
    chk("irq nack", irq, 1'b1);
    wr(8'h00, 32'h0000_000E);
    repeat (40) @(posedge ref_clk);
    rd(8'h0C); chk("ifg stop", rv, 32'h0000_000C);
    rd(8'h04); chk("stat free", rv, 32'h0000_0000);
    // Foreign start clears pending no-ack flag and drops the line
    i_ims_peer.start();
    settle();
    chk("irq hw clr", irq, 1'b0);
    rd(8'h0C); chk("ifg hw clr", rv, 32'h0000_0002);
    i_ims_peer.clocks(1);
    i_ims_peer.stop();
    settle();
    rd(8'h04); chk("stat end", rv, 32'h0000_0000);
    // Repeated start only with the clock slowed below 50 kHz
    wr(8'h14, 32'h0000_012C);
    rd(8'h14); chk("div slow", rv, 32'h0000_012C);
    wr(8'h00, 32'h0000_000D);
    repeat (700) @(posedge ref_clk);
    wr(8'h0C, 32'h0000_000F);
    wr(8'h00, 32'h0000_000D);
    repeat (1000) @(posedge ref_clk);
    rd(8'h00); chk("ctrl rs done", rv, 32'h0000_000C);
    rd(8'h0C); chk("ifg rs", rv, 32'h0000_0003);
    wr(8'h00, 32'h0000_000E);
    repeat (700) @(posedge ref_clk);
    rd(8'h04); chk("stat rs end", rv, 32'h0000_0000);
    results();
  end
endmodule // ims_core_bench

// ### bench/ims_peer.sv
`timescale 1ns/1ns

module ims_peer (
  output logic scl_oe,
  output logic sda_oe
);
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end

  // Data falls while the clock is high
  task automatic start();
    sda_oe = 1'b1;
    #80 scl_oe = 1'b1;
  endtask

  // Clock stands still between calls; data released so the pull-up shows
  task automatic clocks(input int n);
    repeat (n) begin
      #40 sda_oe = 1'b0;
      #40 scl_oe = 1'b0;
      #80 scl_oe = 1'b1;
    end
  endtask

  task automatic stop();
    #40 sda_oe = 1'b1;
    #40 scl_oe = 1'b0;
    #80 sda_oe = 1'b0;
  endtask
endmodule // ims_peer

// ### design/ims_core.sv
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ns

module ims_core
  import ims_pkg::*;
#(
  parameter int SCL_QTR_CYC = `IMS_QTR_CYC
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic [`IMS_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  input  wire logic                   scl_i,
  output logic                        scl_o,
  output logic                        scl_oe,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe,
  output logic                        irq
);

  initial begin
    if (SCL_QTR_CYC < 2 || SCL_QTR_CYC >= (1 << `IMS_DIV_W))
      $error("SCL_QTR_CYC out of range");
  end

  localparam logic [`IMS_DIV_W-1:0] DIV_RST = `IMS_DIV_W'(SCL_QTR_CYC);

  localparam ims_state_s RST = '{
    st: IMS_IDLE, cnt: '0, div: DIV_RST, start_request_bit: 1'b0, stop_req: 1'b0,
    transmitter_select: 1'b0, multi_master_select: 1'b0, transmit_holding_reg: 8'h00,
    txfull: 1'b0, shreg: 8'h00, bitn: 3'h0, bus_busy_flag: 1'b0, ifg: '0, ie: '0,
    scl_oe: 1'b0, sda_oe: 1'b0, irq: 1'b0, rdata: `IMS_ZERO32, scl_d: 1'b1, sda_d: 1'b1};

  ims_state_s r;
  ims_state_s n;
  logic [1:0] line_s;
  logic       scl_s;
  logic       sda_s;

  ims_sync #(.WIDTH(2)) u_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .async_in ({scl_i, sda_i}),
    .sync_out (line_s)
  );
  assign scl_s = line_s[1];
  assign sda_s = line_s[0];

  function automatic logic hit(input logic [`IMS_ADDR_W-1:0] a,
                               input logic [`IMS_ADDR_W-1:0] off);
    return a == off;
  endfunction

  logic start_det;
  logic stop_det;
  logic scl_fall;
  logic tick;
  logic [`IMS_IFG_W-1:0] ifg_set;
  logic [`IMS_IFG_W-1:0] ifg_hwclr;
  logic [`IMS_IFG_W-1:0] ifg_swclr;
  logic tx_wr;

  assign start_det = r.scl_d && scl_s && r.sda_d && !sda_s;
  assign stop_det  = r.scl_d && scl_s && !r.sda_d && sda_s;
  assign scl_fall  = r.scl_d && !scl_s;
  assign tick      = r.cnt == r.div - `IMS_DIV_W'(1);
  assign tx_wr     = reg_wr && hit(reg_addr, `IMS_OFF_TXD);

  always_comb begin
    n = r;
    n.scl_d = scl_s;
    n.sda_d = sda_s;
    n.cnt = tick ? '0 : r.cnt + `IMS_DIV_W'(1);
    ifg_set = '0;
    ifg_hwclr = '0;
    ifg_swclr = '0;

    // Bus busy follows the line, not our own engine
    if (start_det)
      n.bus_busy_flag = 1'b1;
    else if (stop_det)
      n.bus_busy_flag = 1'b0;

    ifg_set[`IMS_IFG_STT] = start_det;
    ifg_set[`IMS_IFG_STP] = stop_det;
    ifg_hwclr[`IMS_IFG_STT] = stop_det;
    ifg_hwclr[`IMS_IFG_STP] = start_det;
    ifg_hwclr[`IMS_IFG_NACK] = start_det;

    if (reg_wr) begin
      if (hit(reg_addr, `IMS_OFF_CTRL)) begin
        n.start_request_bit   = r.start_request_bit | reg_wdata[`IMS_CTRL_START];
        n.stop_req            = r.stop_req | reg_wdata[`IMS_CTRL_STOP];
        n.transmitter_select  = reg_wdata[`IMS_CTRL_TR];
        n.multi_master_select = reg_wdata[`IMS_CTRL_MM];
      end
      if (hit(reg_addr, `IMS_OFF_IFG))
        ifg_swclr = reg_wdata[`IMS_IFG_W-1:0];
      if (hit(reg_addr, `IMS_OFF_IE))
        n.ie = reg_wdata[`IMS_IFG_W-1:0];
      if (hit(reg_addr, `IMS_OFF_DIV) && reg_wdata[`IMS_DIV_W-1:0] > `IMS_DIV_W'(1))
        n.div = reg_wdata[`IMS_DIV_W-1:0];
    end

    // Buffer write in the bus wait is discarded
    if (tx_wr && r.st != IMS_WAIT) begin
      n.transmit_holding_reg = reg_wdata[7:0];
      n.txfull = 1'b1;
      ifg_swclr[`IMS_IFG_TX] = 1'b1;
    end

    case (r.st)
      IMS_IDLE: begin
        n.cnt = '0;
        if (r.start_request_bit) begin
          if (r.multi_master_select && r.bus_busy_flag)
            n.st = IMS_WAIT;
          else
            n.st = IMS_STA_A;
        end
      end
      IMS_WAIT: begin
        n.cnt = '0;
        // Foreign clock traffic still steps the ready flag
        if (r.transmitter_select && scl_fall)
          ifg_set[`IMS_IFG_TX] = 1'b1;
        // No bus-free delay: start follows release at once
        if (!r.bus_busy_flag)
          n.st = IMS_STA_A;
      end
      IMS_STA_A: begin
        n.scl_oe = 1'b0;
        n.sda_oe = 1'b0;
        if (tick && scl_s)
          n.st = IMS_STA_B;
        else if (!scl_s)
          n.cnt = '0;
      end
      IMS_STA_B: begin
        n.sda_oe = 1'b1;
        if (tick) begin
          n.st = IMS_HOLD;
          n.scl_oe = 1'b1;
          n.start_request_bit = 1'b0;
          n.txfull = 1'b0;
          ifg_set[`IMS_IFG_TX] = r.transmitter_select;
        end
      end
      IMS_HOLD: begin
        n.cnt = '0;
        if (r.start_request_bit)
          n.st = IMS_RS;
        else if (r.stop_req)
          n.st = IMS_STP_A;
        else if (r.txfull) begin
          n.shreg = r.transmit_holding_reg;
          n.txfull = 1'b0;
          n.bitn = `IMS_BIT_MSB;
          n.st = IMS_LOW;
        end
      end
      IMS_LOW: begin
        n.sda_oe = !r.shreg[r.bitn];
        if (tick) begin
          n.scl_oe = 1'b0;
          n.st = IMS_HIGH;
        end
      end
      IMS_HIGH: begin
        if (!scl_s)
          n.cnt = '0;
        else if (tick) begin
          n.scl_oe = 1'b1;
          n.bitn = r.bitn - 3'h1;
          n.st = (r.bitn == 3'h0) ? IMS_ACK_L : IMS_LOW;
        end
      end
      IMS_ACK_L: begin
        n.sda_oe = 1'b0;
        if (tick) begin
          n.scl_oe = 1'b0;
          n.st = IMS_ACK_H;
        end
      end
      IMS_ACK_H: begin
        if (!scl_s)
          n.cnt = '0;
        else if (tick) begin
          n.scl_oe = 1'b1;
          n.st = IMS_HOLD;
          ifg_set[`IMS_IFG_NACK] = sda_s;
          ifg_set[`IMS_IFG_TX] = !sda_s;
        end
      end
      IMS_RS: begin
        // Release data while clock is low, then rebuild a start
        n.sda_oe = 1'b0;
        if (tick) begin
          n.scl_oe = 1'b0;
          n.st = IMS_STA_A;
        end
      end
      IMS_STP_A: begin
        n.sda_oe = 1'b1;
        if (tick) begin
          n.scl_oe = 1'b0;
          n.st = IMS_STP_B;
        end
      end
      IMS_STP_B: begin
        if (!scl_s)
          n.cnt = '0;
        else if (tick) begin
          n.sda_oe = 1'b0;
          n.stop_req = 1'b0;
          n.st = IMS_IDLE;
        end
      end
      default: begin
        n.st = IMS_IDLE;
        n.scl_oe = 1'b0;
        n.sda_oe = 1'b0;
      end
    endcase

    // Set beats either clear
    n.ifg = (r.ifg & ~ifg_swclr & ~ifg_hwclr) | ifg_set;
    // Registered from next flags, so a bus clear drops the line next edge
    n.irq = |(n.ifg & n.ie);

    n.rdata = `IMS_ZERO32;
    if (reg_rd) begin
      if (hit(reg_addr, `IMS_OFF_CTRL))
        n.rdata = {28'h000_0000, r.multi_master_select, r.transmitter_select,
                   r.stop_req, r.start_request_bit};
      else if (hit(reg_addr, `IMS_OFF_STAT))
        n.rdata = {30'h0000_0000, r.st == IMS_WAIT, r.bus_busy_flag};
      else if (hit(reg_addr, `IMS_OFF_TXD))
        n.rdata = {24'h00_0000, r.transmit_holding_reg};
      else if (hit(reg_addr, `IMS_OFF_IFG))
        n.rdata = {28'h000_0000, r.ifg};
      else if (hit(reg_addr, `IMS_OFF_IE))
        n.rdata = {28'h000_0000, r.ie};
      else if (hit(reg_addr, `IMS_OFF_DIV))
        n.rdata = {16'h0000, r.div};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn)
      r <= RST;
    else
      r <= n;
  end

  assign reg_rdata = r.rdata;
  assign scl_oe    = r.scl_oe;
  assign sda_oe    = r.sda_oe;
  assign irq       = r.irq;
  assign scl_o     = RST.scl_oe;
  assign sda_o     = RST.sda_oe;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence busy_start_req;
    r.st == IMS_IDLE && r.start_request_bit && r.multi_master_select && r.bus_busy_flag;
  endsequence
  sequence released;
    r.st == IMS_WAIT && !r.bus_busy_flag;
  endsequence

  busy_wait_a: assert property (busy_start_req |=> r.st == IMS_WAIT)
    else $error("start on busy bus did not wait");
  release_start_a: assert property (released |=> r.st == IMS_STA_A && !r.sda_oe)
    else $error("start not issued on bus release");
  wait_hold_a: assert property (r.st == IMS_WAIT && r.bus_busy_flag |=> r.st == IMS_WAIT)
    else $error("left wait while bus busy");
  wait_drop_a: assert property (r.st == IMS_WAIT && tx_wr |=> !r.txfull)
    else $error("buffer write kept during wait");
  wait_txflag_a: assert property (r.st == IMS_WAIT && r.transmitter_select && scl_fall
                                  |=> r.ifg[`IMS_IFG_TX])
    else $error("ready flag not stepped by foreign clock");
  rs_timing_a: assert property (r.st == IMS_STA_B && tick |=> r.st == IMS_HOLD
                                ##0 $past(r.cnt) == r.div - `IMS_DIV_W'(1))
    else $error("start hold not one quarter bit");
  stop_clr_a: assert property (stop_det && !(reg_wr && hit(reg_addr, `IMS_OFF_IFG))
                               |=> !r.ifg[`IMS_IFG_STT] ##1 !r.irq || r.ifg != '0)
    else $error("stop did not clear start flag");
  start_clr_a: assert property (start_det |=> r.ifg[`IMS_IFG_STT] && !r.ifg[`IMS_IFG_STP]
                                && !r.ifg[`IMS_IFG_NACK])
    else $error("start did not clear stop or no-ack");
  irq_follow_a: assert property ((r.ifg & r.ie) == '0 |=> !r.irq || $past(ifg_set) != '0
                                 || $past(reg_wr))
    else $error("interrupt without unmasked flag");
  read_next_a: assert property (reg_rd && hit(reg_addr, `IMS_OFF_STAT)
                                |=> reg_rdata[`IMS_STAT_BUSY] == $past(r.bus_busy_flag))
    else $error("status read data wrong");

endmodule // ims_core

// ### design/ims_defines.svh
`ifndef IMS_DEFINES_SVH
`define IMS_DEFINES_SVH

`define IMS_CLK_HZ        50000000
`define IMS_SCL_STD_HZ    100000
`define IMS_QTR_CYC       (`IMS_CLK_HZ / (4 * `IMS_SCL_STD_HZ))
`define IMS_DIV_W         16
`define IMS_ADDR_W        8

`define IMS_OFF_CTRL      8'h00
`define IMS_OFF_STAT      8'h04
`define IMS_OFF_TXD       8'h08
`define IMS_OFF_IFG       8'h0C
`define IMS_OFF_IE        8'h10
`define IMS_OFF_DIV       8'h14

`define IMS_CTRL_START    0
`define IMS_CTRL_STOP     1
`define IMS_CTRL_TR       2
`define IMS_CTRL_MM       3

`define IMS_STAT_BUSY     0
`define IMS_STAT_WAIT     1

`define IMS_IFG_TX        0
`define IMS_IFG_STT       1
`define IMS_IFG_STP       2
`define IMS_IFG_NACK      3
`define IMS_IFG_W         4

`define IMS_BIT_MSB       3'h7
`define IMS_ZERO32        32'h0000_0000

`endif

// ### design/ims_pkg.sv
`include "ims_defines.svh"

package ims_pkg;

  typedef enum logic [3:0] {
    IMS_IDLE   = 4'b0000,
    IMS_WAIT   = 4'b0001,
    IMS_STA_A  = 4'b0010,
    IMS_STA_B  = 4'b0011,
    IMS_HOLD   = 4'b0100,
    IMS_LOW    = 4'b0101,
    IMS_HIGH   = 4'b0110,
    IMS_ACK_L  = 4'b0111,
    IMS_ACK_H  = 4'b1000,
    IMS_STP_A  = 4'b1001,
    IMS_STP_B  = 4'b1010,
    IMS_RS     = 4'b1011
  } ims_state_e;

  typedef struct packed {
    ims_state_e              st;
    logic [`IMS_DIV_W-1:0]   cnt;
    logic [`IMS_DIV_W-1:0]   div;
    logic                    start_request_bit;
    logic                    stop_req;
    logic                    transmitter_select;
    logic                    multi_master_select;
    logic [7:0]              transmit_holding_reg;
    logic                    txfull;
    logic [7:0]              shreg;
    logic [2:0]              bitn;
    logic                    bus_busy_flag;
    logic [`IMS_IFG_W-1:0]   ifg;
    logic [`IMS_IFG_W-1:0]   ie;
    logic                    scl_oe;
    logic                    sda_oe;
    logic                    irq;
    logic [31:0]             rdata;
    logic                    scl_d;
    logic                    sda_d;
  } ims_state_s;

endpackage

// ### design/ims_sync.sv
`timescale 1ns/1ns

module ims_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      // Reset high: an idle open-drain line reads as released
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          meta_reg[i] <= 1'b1;
          sync_out[i] <= 1'b1;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule // ims_sync
